/* nvpc_control.sv */
// Program control for the one-time-programmable array and byte-erasable memory.
// Assumes a CPU-side register port with read data one cycle later; the arrays'
// storage cells and high voltage circuits sit outside behind the given strobes.
`timescale 1ns/1ps
module nvpc_control
	import nvpc_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic porEvent,
	input wire logic extResetInN,
	input wire logic stopEnter,
	input wire logic waitMode,
	input wire logic bootstrapMode,
	input wire nvpc_bus_req_t busReq,
	output logic [7:0] busRdata,
	input wire logic [7:0] arrayCellData,
	input wire logic [7:0] byteMemCellData,
	input wire logic [7:0] factoryOptionCell,
	input wire logic [7:0] optionsCell,
	input wire logic [7:0] portBDir,
	input wire logic [7:0] portCDir,
	output logic mcuResetN,
	output logic arrayLatchWrite,
	output logic [15:0] arrayLatchAddr,
	output logic [7:0] arrayLatchData,
	output logic arrayProgramActive,
	output logic byteMemLoad,
	output logic [7:0] byteMemLoadData,
	output logic byteMemEraseRun,
	output logic byteMemProgramRun,
	output logic byteMemProtectedHit,
	output logic clockOutputEnable,
	output logic securityActive,
	output nvpc_opts_t optsOut
);
	// Array programming state: latch and program enables, plus the group tracker
	logic arrayLatchEnable_reg;
	logic arrayLatchEnable_next;
	logic arrayProgramEnable_reg;
	logic arrayProgramEnable_next;
	logic arrayWritten_reg;
	logic [15:0] groupBase_reg;

	// Byte memory state: erase select, latch, pump and what has been taken so far
	logic byteEraseSelect_reg;
	logic byteEraseSelect_next;
	logic byteLatchEnable_reg;
	logic byteLatchEnable_next;
	logic bytePumpEnable_reg;
	logic bytePumpEnable_next;
	logic byteAddrLatched_reg;
	logic byteDataLatched_reg;
	logic byteProtBlock_reg;

	// Clock output bit and the registered read data
	logic clockOutputEnable_reg;
	logic [7:0] rdata_reg;

	// Reset sequencing and the options captured when reset lets go
	logic [2:0] extLowCnt_reg;
	logic [11:0] porCnt_reg;
	nvpc_state_t state_reg;
	logic secLatched_reg;
	logic rwatLatched_reg;
	logic resetHold_reg;

	// Address decodes for the register port
	// The control register sits at one fixed address; the array answers over its
	// main block, its vector block and the factory option byte.
	wire logic hitCtrl = busReq.addr == `NVPC_ADDR_CTRL;
	wire logic hitArrayMain = busReq.addr >= `NVPC_ARR_LO && busReq.addr <= `NVPC_ARR_HI;
	wire logic hitArrayVec = busReq.addr >= `NVPC_VEC_LO && busReq.addr <= `NVPC_VEC_HI;
	wire logic hitArrayFob = busReq.addr == `NVPC_ADDR_FOB;
	wire logic hitArray = hitArrayMain || hitArrayVec || hitArrayFob;

	// Byte memory window runs from the options byte to the top of the protected part
	wire logic hitByteMem = busReq.addr >= `NVPC_ADDR_OPTS && busReq.addr <= `NVPC_PROT_HI;
	wire logic hitProt = busReq.addr >= `NVPC_PROT_LO && busReq.addr <= `NVPC_PROT_HI;
	wire logic ctrlWr = busReq.wr && hitCtrl;
	wire logic [7:0] wd = busReq.wdata;

	// Stop entry and any reset hold drop both latch bits; such a clear always wins
	// over a software set written in the same cycle.
	wire logic clearAll = stopEnter || !resetHold_reg;
	// Protection of the upper byte-memory part is lifted in bootstrap mode
	wire logic protectOn = !optionsCell[`NVPC_OPT_PROT] && !bootstrapMode;

	// Array write latched only while enabled and not programming
	wire logic arrayWr = busReq.wr && hitArray && arrayLatchEnable_reg && !arrayProgramEnable_reg;
	// Group check keeps all bytes in one sixteen-byte group; a write that lands
	// outside the first byte's group is dropped so one pulse never mixes groups.
	wire logic inGroup = !arrayWritten_reg || busReq.addr[15:4] == groupBase_reg[15:4];
	// Byte memory loads are taken while its latch is set and the pump is still off
	wire logic byteWr = busReq.wr && hitByteMem && byteLatchEnable_reg && !bytePumpEnable_reg;
	wire logic byteWrOk = byteWr && !(hitProt && protectOn);

	// Program-enable set request: latch already on and a group byte already taken
	wire logic arrayPgmSetReq = ctrlWr && wd[`NVPC_BIT_APGM]
		&& arrayLatchEnable_reg && arrayWritten_reg;
	// Pump set request: an erase needs its address, a program needs its data
	wire logic byteSelected = byteEraseSelect_reg ? byteAddrLatched_reg : byteDataLatched_reg;
	wire logic bytePumpSetReq = ctrlWr && wd[`NVPC_BIT_BPGM] && byteLatchEnable_reg
		&& byteSelected;
	// Erase select may change only until the first byte-memory address is taken
	wire logic byteEraseWrOk = ctrlWr && !byteAddrLatched_reg;

	// Next values of the control bits
	// Writing zero to either enable bit is ignored; only its latch bit clears it,
	// which keeps a stray write from cutting a programming pulse short.
	assign arrayLatchEnable_next = clearAll ? 1'b0
		: ctrlWr ? wd[`NVPC_BIT_ALAT] : arrayLatchEnable_reg;
	assign arrayProgramEnable_next = (clearAll || !arrayLatchEnable_next) ? 1'b0
		: (arrayProgramEnable_reg || arrayPgmSetReq);
	assign byteLatchEnable_next = clearAll ? 1'b0
		: ctrlWr ? wd[`NVPC_BIT_BLAT] : byteLatchEnable_reg;
	assign byteEraseSelect_next = !byteLatchEnable_next ? 1'b0
		: byteEraseWrOk ? wd[`NVPC_BIT_BERA] : byteEraseSelect_reg;
	assign bytePumpEnable_next = !byteLatchEnable_next ? 1'b0
		: (bytePumpEnable_reg || bytePumpSetReq);

	// Control and latch state
	// The taken flags fall with their latch bit, so every new latch session
	// starts with a fresh group, a free erase select and the pump locked.
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			arrayLatchEnable_reg <= 1'b0;
			arrayProgramEnable_reg <= 1'b0;
			arrayWritten_reg <= 1'b0;
			byteLatchEnable_reg <= 1'b0;
			byteEraseSelect_reg <= 1'b0;
			bytePumpEnable_reg <= 1'b0;
			byteAddrLatched_reg <= 1'b0;
			byteDataLatched_reg <= 1'b0;
			byteProtBlock_reg <= 1'b0;
			clockOutputEnable_reg <= 1'b0;
			groupBase_reg <= 16'h0000;
		end
		else
		begin
			arrayLatchEnable_reg <= arrayLatchEnable_next;
			arrayProgramEnable_reg <= arrayProgramEnable_next;
			arrayWritten_reg <= arrayLatchEnable_next && (arrayWritten_reg || (arrayWr && inGroup));
			if (arrayWr && inGroup && !arrayWritten_reg)
				groupBase_reg <= busReq.addr;
			byteLatchEnable_reg <= byteLatchEnable_next;
			byteEraseSelect_reg <= byteEraseSelect_next;
			bytePumpEnable_reg <= bytePumpEnable_next;
			byteAddrLatched_reg <= byteLatchEnable_next && (byteAddrLatched_reg || byteWr);
			byteDataLatched_reg <= byteLatchEnable_next && (byteDataLatched_reg || byteWr);
			byteProtBlock_reg <= byteLatchEnable_next
				&& ((byteProtBlock_reg && !byteWrOk) || (byteWr && !byteWrOk));
			if (clearAll)
				clockOutputEnable_reg <= 1'b0;
			else if (ctrlWr)
				clockOutputEnable_reg <= wd[`NVPC_BIT_CLKO];
		end
	end

	// Latch strobes toward the arrays; cumulative one-bit programming is the cell's job
	// Strobes last one cycle; address and data stay put until the next accepted write.
	// A protected byte-memory write gives no load strobe at all.
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			arrayLatchWrite <= 1'b0;
			arrayLatchAddr <= 16'h0000;
			arrayLatchData <= 8'h00;
			byteMemLoad <= 1'b0;
			byteMemLoadData <= 8'h00;
		end
		else
		begin
			arrayLatchWrite <= arrayWr && inGroup;
			if (arrayWr && inGroup)
			begin
				arrayLatchAddr <= busReq.addr;
				arrayLatchData <= wd;
			end
			byteMemLoad <= byteWrOk;
			if (byteWrOk)
				byteMemLoadData <= wd;
		end
	end

	// Read data selection
	// With the array latch set, array reads return a fixed filler, never the cells,
	// so code fetched from the array while latched cannot run.
	wire logic [7:0] ctrlRd = {2'b00, arrayLatchEnable_reg, arrayProgramEnable_reg,
		clockOutputEnable_reg, byteEraseSelect_reg, byteLatchEnable_reg, bytePumpEnable_reg};
	wire logic [7:0] arrayRd = arrayLatchEnable_reg ? `NVPC_GARBAGE : arrayCellData;
	wire logic [7:0] rdMux = hitCtrl ? ctrlRd
		: hitArray ? arrayRd
		: hitByteMem ? byteMemCellData : 8'h00;

	// Read data register
	// Holds the selected byte for exactly the cycle after a read strobe and
	// reads zero otherwise, so a late sample is easy to spot.
	always_ff @(posedge clk)
	begin
		if (!rstn)
			rdata_reg <= 8'h00;
		else if (busReq.rd)
			rdata_reg <= rdMux;
		else
			rdata_reg <= 8'h00;
	end

	// External reset qualifier: three consecutive low cycles
	// Shorter glitches on the reset pin reset the count without taking effect.
	always_ff @(posedge clk)
	begin
		if (!rstn || extResetInN)
			extLowCnt_reg <= 3'd0;
		else if (extLowCnt_reg != `NVPC_RST_MIN_CYC)
			extLowCnt_reg <= extLowCnt_reg + 3'd1;
	end
	wire logic extReset = extLowCnt_reg == `NVPC_RST_MIN_CYC;
	wire logic [11:0] porLen = factoryOptionCell[`NVPC_FOB_RESET_TIME_OPTION] ? `NVPC_POR_SHORT
		: `NVPC_POR_LONG;

	// Reset hold sequencer and options captured at reset release
	// A power-on event restarts the full hold; a qualified external reset holds
	// until one cycle after the pin rises and then samples the security and watchdog options afresh.
	always_ff @(posedge clk)
	begin
		if (!rstn || porEvent)
		begin
			state_reg <= NVPC_POR_HOLD;
			porCnt_reg <= 12'd0;
			resetHold_reg <= 1'b0;
			secLatched_reg <= 1'b0;
			rwatLatched_reg <= 1'b0;
		end
		else if (extReset)
		begin
			state_reg <= NVPC_RUN;
			resetHold_reg <= 1'b0;
			porCnt_reg <= 12'd0;
		end
		else
		begin
			unique case (state_reg)
				// Count out the hold length chosen by the reset-time option
				NVPC_POR_HOLD:
				begin
					porCnt_reg <= porCnt_reg + 12'd1;
					if (porCnt_reg + 12'd1 >= porLen)
						state_reg <= NVPC_RUN;
				end
				// First run cycle captures the options, then reset is let go
				NVPC_RUN:
				begin
					if (!resetHold_reg)
					begin
						secLatched_reg <= !optionsCell[`NVPC_OPT_SEC];
						rwatLatched_reg <= factoryOptionCell[`NVPC_FOB_RESET_WATCHDOG_OPTION]
							&& !bootstrapMode;
					end
					resetHold_reg <= 1'b1;
				end
				default:
					state_reg <= NVPC_POR_HOLD;
			endcase
		end
	end

	// Outputs
	// Read data, reset and the enable bits come straight from flops
	assign busRdata = rdata_reg;
	assign mcuResetN = resetHold_reg;
	assign arrayProgramActive = arrayProgramEnable_reg;

	// Byte memory mode decode from erase select, latch and pump bits
	wire logic [2:0] byteMode = {byteEraseSelect_reg, byteLatchEnable_reg, bytePumpEnable_reg};
	wire logic byteModeProgram = byteMode == 3'b011;
	wire logic byteModeErase = byteMode == 3'b111;
	// A blocked protected access keeps the high voltage off the cells
	assign byteMemEraseRun = byteModeErase && !byteProtBlock_reg;
	assign byteMemProgramRun = byteModeProgram && !byteProtBlock_reg;
	assign byteMemProtectedHit = byteProtBlock_reg;
	assign clockOutputEnable = clockOutputEnable_reg;
	assign securityActive = secLatched_reg;

	// Watchdog enable is captured with the other options in the first run cycle,
	// so it is already on when reset lets go; in wait mode the wait option must also be set.
	assign optsOut.watchdogOn = waitMode
		? (rwatLatched_reg && factoryOptionCell[`NVPC_FOB_WAIT_WATCHDOG_OPTION])
		: rwatLatched_reg;
	// Pull-downs per pin only while that pin is an input
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : gPull
			assign optsOut.portBPulldown[gi] = factoryOptionCell[`NVPC_FOB_PORT_B_PULLDOWN_OPTION] && !portBDir[gi];
			assign optsOut.portCPulldown[gi] = factoryOptionCell[`NVPC_FOB_PORT_C_PULLDOWN_OPTION] && !portCDir[gi];
		end
	endgenerate
endmodule : nvpc_control

/* nvpc_defines.svh */
// Constants for the nonvolatile program control block.
// Included by the package only; definitions only.
`ifndef NVPC_DEFINES_SVH
`define NVPC_DEFINES_SVH
`define NVPC_ADDR_CTRL 16'h0007
`define NVPC_ADDR_OPTS 16'h0100
`define NVPC_ADDR_FOB 16'h7fde
`define NVPC_ARR_LO 16'h0400
`define NVPC_ARR_HI 16'h7dff
`define NVPC_VEC_LO 16'h7ff2
`define NVPC_VEC_HI 16'h7fff
`define NVPC_PROT_LO 16'h0120
`define NVPC_PROT_HI 16'h01ff
`define NVPC_BIT_ALAT 5
`define NVPC_BIT_APGM 4
`define NVPC_BIT_CLKO 3
`define NVPC_BIT_BERA 2
`define NVPC_BIT_BLAT 1
`define NVPC_BIT_BPGM 0
`define NVPC_OPT_PROT 1
`define NVPC_OPT_SEC 0
`define NVPC_FOB_RESET_TIME_OPTION 4
`define NVPC_FOB_RESET_WATCHDOG_OPTION 3
`define NVPC_FOB_WAIT_WATCHDOG_OPTION 2
`define NVPC_FOB_PORT_B_PULLDOWN_OPTION 1
`define NVPC_FOB_PORT_C_PULLDOWN_OPTION 0
`define NVPC_ERASED 8'h00
`define NVPC_GARBAGE 8'hff
`define NVPC_RST_MIN_CYC 3'd3
`define NVPC_POR_SHORT 12'd16
`define NVPC_POR_LONG 12'd4064
`define NVPC_GROUP 16
`endif

/* nvpc_pkg.sv */
// Types shared by the nonvolatile program control block.
// Needs nvpc_defines.svh on the include path.
`include "nvpc_defines.svh"
package nvpc_pkg;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} nvpc_bus_req_t;
	typedef enum logic [1:0] {
		NVPC_POR_HOLD = 2'b00,
		NVPC_RUN = 2'b01
	} nvpc_state_t;
	typedef struct packed {
		logic watchdogOn;
		logic [7:0] portBPulldown;
		logic [7:0] portCPulldown;
	} nvpc_opts_t;
endpackage : nvpc_pkg

/* nvpc_supply_model.sv */
// Model of the external programming supply switch and a group of array cells.
// Assumes the control block's latch strobe, latch address/data and enable outputs.
`timescale 1ns/1ps
module nvpc_supply_model
(
	input wire logic clk,
	input wire logic latchWr,
	input wire logic [15:0] latchAddr,
	input wire logic [7:0] latchData,
	input wire logic progEn,
	input wire logic [15:0] rdAddr,
	output logic [7:0] cellData,
	output logic supplyOn
);
	logic [7:0] cellMem [16];
	logic [7:0] pendMem [16];
	// Cells read as erased until programmed
	assign cellData = cellMem[rdAddr[3:0]];
	initial
	begin
		foreach (cellMem[i])
		begin
			cellMem[i] = 8'h00;
			pendMem[i] = 8'h00;
		end
		supplyOn = 1'b0;
	end
	// Supply switched only after enable; programming only adds ones
	always @(posedge clk)
	begin
		supplyOn <= progEn;
		if (latchWr)
			pendMem[latchAddr[3:0]] <= latchData;
		if (supplyOn)
			foreach (cellMem[i])
				cellMem[i] <= cellMem[i] | pendMem[i];
	end
endmodule : nvpc_supply_model

/* nvpc_control_props.sv */
// Concurrent checks on the control block's ports.
// Bound to every nvpc_control instance; one clock domain.
`timescale 1ns/1ps
module nvpc_control_props
	import nvpc_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic porEvent,
	input wire logic extResetInN,
	input wire logic stopEnter,
	input wire nvpc_bus_req_t busReq,
	input wire logic [7:0] busRdata,
	input wire logic mcuResetN,
	input wire logic arrayLatchWrite,
	input wire logic arrayProgramActive,
	input wire logic byteMemLoad,
	input wire logic byteMemEraseRun,
	input wire logic byteMemProgramRun,
	input wire logic byteMemProtectedHit
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// Control writes, and those that drop the array latch
	wire ctrlWr = busReq.wr && busReq.addr == 16'h0007;
	wire latchOff = ctrlWr && !busReq.wdata[5];
	sequence sCtrlRead;
		busReq.rd && busReq.addr == 16'h0007;
	endsequence
	sequence sExtLow;
		!extResetInN [*3];
	endsequence
	AST_RDATA_IDLE: assert property (!busReq.rd |=> busRdata == 8'h00)
		else $error("read data not zero outside a read");
	AST_CTRL_READ: assert property (sCtrlRead |=> busRdata[7:6] == 2'b00)
		else $error("control read upper bits not zero");
	AST_LATCH_CAUSE: assert property (arrayLatchWrite |-> $past(busReq.wr)
		&& $past(busReq.addr) >= 16'h0400) else $error("latch strobe without array write");
	AST_PGM_SET: assert property ($rose(arrayProgramActive) |-> $past(ctrlWr)
		&& $past(busReq.wdata[4])) else $error("program enable rose without request");
	AST_PGM_HOLD: assert property (arrayProgramActive && !latchOff && !stopEnter
		&& !porEvent && extResetInN && mcuResetN |=> arrayProgramActive)
		else $error("program enable lost");
	AST_LATCH_CLEAR: assert property (latchOff |=> !arrayProgramActive)
		else $error("program enable survives latch clear");
	AST_STOP: assert property (stopEnter |=> !arrayProgramActive && !byteMemEraseRun
		&& !byteMemProgramRun) else $error("stop left a program mode on");
	AST_EXT_RESET: assert property (sExtLow |-> ##[0:2] !mcuResetN)
		else $error("external reset not taken");
	AST_RUN_EXCL: assert property (!(byteMemEraseRun && byteMemProgramRun))
		else $error("erase and program run together");
	AST_PUMP_CAUSE: assert property ($rose(byteMemEraseRun || byteMemProgramRun)
		|-> $past(ctrlWr) && $past(busReq.wdata[0])) else $error("pump on without request");
	AST_PROT_NOLOAD: assert property (byteMemProtectedHit |-> !byteMemLoad)
		else $error("protected location loaded");
endmodule : nvpc_control_props
bind nvpc_control nvpc_control_props uProps (.clk, .rstn, .porEvent, .extResetInN,
	.stopEnter, .busReq, .busRdata, .mcuResetN, .arrayLatchWrite, .arrayProgramActive,
	.byteMemLoad, .byteMemEraseRun, .byteMemProgramRun, .byteMemProtectedHit);

/* test_eprom_eeprom_program_control.sv */
// Self-checking bench for the nonvolatile program control block.
// Assumes the supply model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module test_eprom_eeprom_program_control import nvpc_pkg::*;;
	logic clk = 1'b0, rstn = 1'b0, extResetInN = 1'b1, stopEnter = 1'b0, waitMode = 1'b0;
	nvpc_bus_req_t busReq = '0;
	logic [7:0] portBDir = 8'h0f, portCDir = 8'hf0, optsCell = 8'h01;
	logic [7:0] busRdata, arrayCellData, arrayLatchData, byteMemLoadData;
	logic [15:0] arrayLatchAddr;
	logic mcuResetN, arrayLatchWrite, arrayProgramActive, byteMemLoad, byteMemEraseRun;
	logic byteMemProgramRun, byteMemProtectedHit, clockOutputEnable, securityActive, supplyOn;
	nvpc_opts_t optsOut;
	int n_errors = 0, num_checks = 0, cnt;
	always #10 clk = ~clk;
	nvpc_control DUT (.clk, .rstn, .porEvent(1'b0), .extResetInN, .stopEnter, .waitMode,
		.bootstrapMode(1'b0), .busReq, .busRdata, .arrayCellData, .byteMemCellData(8'h00),
		.factoryOptionCell(8'h1f), .optionsCell(optsCell), .portBDir, .portCDir, .mcuResetN,
		.arrayLatchWrite, .arrayLatchAddr, .arrayLatchData, .arrayProgramActive, .byteMemLoad,
		.byteMemLoadData, .byteMemEraseRun, .byteMemProgramRun, .byteMemProtectedHit,
		.clockOutputEnable, .securityActive, .optsOut);
	nvpc_supply_model uSupply (.clk, .latchWr(arrayLatchWrite), .latchAddr(arrayLatchAddr),
		.latchData(arrayLatchData), .progEn(arrayProgramActive), .rdAddr(busReq.addr),
		.cellData(arrayCellData), .supplyOn);
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		busReq <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		busReq <= '0;
		#1;
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] e, input string what);
		@(posedge clk);
		busReq <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		busReq <= '0;
		#1;
		chk(busRdata, e, what);
	endtask : rd
	task automatic waitRun;
		cnt = 0;
		while (mcuResetN !== 1'b1 && cnt < 5000)
		begin
			@(posedge clk);
			#1;
			cnt++;
		end
	endtask : waitRun
	task automatic conclude;
		$display("Checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude
	// Cut a hang short
	initial
	begin
		#200000;
		n_errors++;
		conclude();
	end
	// Main sequence
	initial
	begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		waitRun();
		chk(cnt inside {[16:20]}, 1'b1, "hold");
		chk(optsOut.watchdogOn, 1'b1, "wdog");
		chk(optsOut.portBPulldown, 8'hf0, "pdb");
		chk(optsOut.portCPulldown, 8'h0f, "pdc");
		chk(securityActive, 1'b0, "sec");
		waitMode <= 1'b1;
		@(posedge clk);
		#1;
		chk(optsOut.watchdogOn, 1'b1, "wdog wait");
		rd(16'h0007, 8'h00, "ctrl");
		wr(16'h0007, 8'h10);
		rd(16'h0007, 8'h00, "pgm nolatch");
		wr(16'h0007, 8'h20);
		wr(16'h0007, 8'h30);
		rd(16'h0007, 8'h20, "pgm nobyte");
		rd(16'h0400, 8'hff, "latched rd");
		wr(16'h0400, 8'h5a);
		chk(arrayLatchWrite, 1'b1, "strobe");
		chk({arrayLatchAddr[3:0], arrayLatchData}, 12'h05a, "latch");
		wr(16'h0413, 8'h5a);
		chk(arrayLatchWrite, 1'b0, "group");
		wr(16'h0007, 8'h30);
		chk(arrayProgramActive, 1'b1, "pgm");
		wr(16'h0007, 8'h20);
		rd(16'h0007, 8'h30, "pgm sticky");
		wr(16'h0007, 8'h00);
		chk(arrayProgramActive, 1'b0, "pgm off");
		rd(16'h0400, 8'h5a, "programmed");
		rd(16'h0401, 8'h00, "erased");
		wr(16'h0007, 8'h06);
		wr(16'h0120, 8'h55);
		chk(byteMemProtectedHit, 1'b1, "prot");
		wr(16'h0110, 8'h55);
		chk(byteMemLoad, 1'b1, "load");
		wr(16'h0007, 8'h03);
		rd(16'h0007, 8'h07, "era frozen");
		chk(byteMemEraseRun, 1'b1, "erase run");
		wr(16'h0007, 8'h00);
		rd(16'h0007, 8'h00, "blat off");
		wr(16'h0007, 8'h02);
		wr(16'h0007, 8'h03);
		rd(16'h0007, 8'h02, "pump early");
		wr(16'h0110, 8'h33);
		wr(16'h0007, 8'h03);
		chk(byteMemProgramRun, 1'b1, "prog run");
		wr(16'h0007, 8'h00);
		wr(16'h0007, 8'h2a);
		stopEnter <= 1'b1;
		@(posedge clk);
		stopEnter <= 1'b0;
		rd(16'h0007, 8'h00, "stop");
		wr(16'h0007, 8'h22);
		optsCell <= 8'h00;
		@(posedge clk);
		#1;
		chk(securityActive, 1'b0, "sec held");
		extResetInN <= 1'b0;
		repeat (4) @(posedge clk);
		extResetInN <= 1'b1;
		#1;
		chk(mcuResetN, 1'b0, "ext rst");
		waitRun();
		rd(16'h0007, 8'h00, "ext clr");
		chk(securityActive, 1'b1, "sec new");
		conclude();
	end
endmodule : test_eprom_eeprom_program_control
